// file: inc/acc_pkg.sv
// constants, types and register map of the comparator control block
// How it works
// - result high when positive input exceeds negative
// - mux enabled, converter off: channel picks pin
// - otherwise dedicated negative pin drives negative input
// - bandgap select bit chooses reference or pin
// - raw output synchronised, one to two cycles
// - mode 00 toggle, 01 reserved, 10 fall, 11 rise
// - matching output event sets interrupt flag
// - request only when flag, enable, global enable
// - vector or written one clears flag
// - capture enable routes output to timer
// - routed output uses timer canceller and edges
// - power-off bit switches comparator off anytime
// - buffer-off bit forces pin read to zero
package acc_pkg;

  // byte addresses on the register bus
  localparam logic [7:0] ACC_OFS_CTRL = 8'h50;
  localparam logic [7:0] ACC_OFS_CONV_B = 8'h54;
  localparam logic [7:0] ACC_OFS_PIN_DIS = 8'h58;

  // comparator_control_status fields
  localparam int ACC_BIT_POWER_OFF = 7;
  localparam int ACC_BIT_BANDGAP = 6;
  localparam int ACC_BIT_RESULT = 5;
  localparam int ACC_BIT_FLAG = 4;
  localparam int ACC_BIT_IRQ_EN = 3;
  localparam int ACC_BIT_CAPTURE = 2;
  localparam int ACC_BIT_MODE_HI = 1;
  localparam int ACC_BIT_MODE_LO = 0;

  // converter_control_status_b field
  localparam int ACC_BIT_MUX_EN = 6;

  // comparator_pin_input_disable fields
  localparam int ACC_BIT_NEG_BUF_OFF = 1;
  localparam int ACC_BIT_POS_BUF_OFF = 0;

  // reset values
  localparam logic [7:0] ACC_RST_CTRL = 8'h00;
  localparam logic [7:0] ACC_RST_CONV_B = 8'h00;
  localparam logic [7:0] ACC_RST_PIN_DIS = 8'h00;
  localparam logic [31:0] ACC_RDATA_IDLE = 32'h0000_0000;

  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'h0,
    ACC_MODE_RSVD = 2'h1,
    ACC_MODE_FALL = 2'h2,
    ACC_MODE_RISE = 2'h3
  } acc_mode_e;

  typedef enum logic [1:0] {
    ACC_BUS_IDLE = 2'h1,
    ACC_BUS_ANS = 2'h2
  } acc_bus_e;

endpackage

// file: logic/acc_edge_flag.sv
// edge classifier and sticky interrupt flag
`timescale 1ns/100ps
module acc_edge_flag (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic level,
  input acc_pkg::acc_mode_e mode,
  input wire logic clear,
  output logic flag
);
  import acc_pkg::*;

  logic prev_r;
  logic prev_nxt;
  logic seen_r;
  logic seen_nxt;
  logic flag_r;
  logic flag_nxt;
  logic rise;
  logic fall;
  logic hit;

  always_comb begin
    rise = seen_r && level && !prev_r;
    fall = seen_r && !level && prev_r;
    case (mode)
      ACC_MODE_TOGGLE: hit = rise || fall;
      ACC_MODE_FALL: hit = fall;
      ACC_MODE_RISE: hit = rise;
      default: hit = 1'b0;
    endcase
    prev_nxt = level;
    seen_nxt = 1'b1;
    // a new event wins over a clear in the same cycle
    flag_nxt = hit ? 1'b1 : (clear ? 1'b0 : flag_r);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev_r <= 1'b0;
      seen_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      seen_r <= seen_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

  a_flag_rise_set: assert property (@(posedge clk_sys) disable iff (srst)
    seen_r && mode == ACC_MODE_RISE && level && !prev_r |=> flag_r)
    else $error("rising edge in rise mode did not set flag");
  a_flag_clear: assert property (@(posedge clk_sys) disable iff (srst)
    clear && !hit |=> !flag_r)
    else $error("clear did not drop flag");
  a_flag_reserved: assert property (@(posedge clk_sys) disable iff (srst)
    mode == ACC_MODE_RSVD && !flag_r |=> !flag_r)
    else $error("reserved mode set the flag");
  a_flag_hold: assert property (@(posedge clk_sys) disable iff (srst)
    flag_r && !clear |=> flag_r)
    else $error("flag dropped without clear");

endmodule

// file: logic/acc_sync.sv
// synchroniser for the raw comparator output
`timescale 1ns/100ps
module acc_sync (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic raw_in,
  output logic level_out
);
  import acc_pkg::*;

  logic meta_r;
  logic meta_nxt;
  logic level_r;
  logic level_nxt;

  // two stages keep the latency at one to two cycles
  always_comb begin
    meta_nxt = raw_in;
    level_nxt = meta_r;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;

  a_sync_latency: assert property (@(posedge clk_sys) disable iff (srst)
    $past(raw_in, 2) == $past(raw_in, 1) |-> level_r == $past(raw_in, 1))
    else $error("synchronised result does not follow raw output");

endmodule

// file: logic/acc_top.sv
// comparator control block with register slave and analogue steering
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
module acc_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic comparator_raw,
  input wire logic converter_enable,
  input wire logic [2:0] channel_select_field,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic [1:0] pin_level,
  output logic comparator_power_off,
  output logic bandgap_select,
  output logic neg_use_mux,
  output logic [2:0] neg_channel,
  output logic capture_trigger,
  output logic comparator_irq,
  output logic positive_pin_buffer_off,
  output logic negative_pin_buffer_off,
  output logic [1:0] pin_read
);
  import acc_pkg::*;

  acc_bus_e bus_state_r;
  acc_bus_e bus_state_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] conv_b_r;
  logic [7:0] conv_b_nxt;
  logic [7:0] pin_dis_r;
  logic [7:0] pin_dis_nxt;

  logic neg_mux_r;
  logic neg_mux_nxt;
  logic [2:0] neg_chan_r;
  logic [2:0] neg_chan_nxt;
  logic capture_r;
  logic capture_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [1:0] pin_read_r;
  logic [1:0] pin_read_nxt;

  logic result;
  logic flag;
  logic commit;
  logic sw_clear;
  logic flag_rd_r;
  logic flag_rd_nxt;

  function automatic logic hit_addr(input logic [7:0] addr, input logic [7:0] ofs);
    hit_addr = (addr == ofs);
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] ctrl,
                                          input logic [7:0] conv_b, input logic [7:0] pin_dis);
    read_mux = 8'h00;
    if (hit_addr(addr, ACC_OFS_CTRL)) begin
      read_mux = ctrl;
    end else if (hit_addr(addr, ACC_OFS_CONV_B)) begin
      read_mux = conv_b;
    end else if (hit_addr(addr, ACC_OFS_PIN_DIS)) begin
      read_mux = pin_dis;
    end
  endfunction

  acc_sync u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .raw_in(comparator_raw),
    .level_out(result)
  );

  acc_edge_flag u_flag (
    .clk_sys(clk_sys),
    .srst(srst),
    .level(result),
    .mode(acc_mode_e'(ctrl_r[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO])),
    .clear(sw_clear || irq_vector_ack),
    .flag(flag)
  );

  // bus: request seen in idle, answered the next cycle with waitrequest low
  always_comb begin
    bus_state_nxt = bus_state_r;
    wait_nxt = wait_r;
    rdata_nxt = rdata_r;
    commit = 1'b0;
    case (bus_state_r)
      ACC_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_state_nxt = ACC_BUS_ANS;
          wait_nxt = 1'b0;
          rdata_nxt = {24'h000000,
                       read_mux(avs_address, ctrl_r, conv_b_r, pin_dis_r)};
        end
      end
      ACC_BUS_ANS: begin
        bus_state_nxt = ACC_BUS_IDLE;
        wait_nxt = 1'b1;
        rdata_nxt = ACC_RDATA_IDLE;
        commit = avs_write && avs_byteenable[0];
      end
      default: begin
        bus_state_nxt = ACC_BUS_IDLE;
        wait_nxt = 1'b1;
        rdata_nxt = ACC_RDATA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_state_r <= ACC_BUS_IDLE;
      wait_r <= 1'b1;
      rdata_r <= ACC_RDATA_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // register file; the result and flag bits are live state, not storage
  always_comb begin
    sw_clear = commit && hit_addr(avs_address, ACC_OFS_CTRL)
               && avs_writedata[ACC_BIT_FLAG];
    ctrl_nxt = ctrl_r;
    conv_b_nxt = conv_b_r;
    pin_dis_nxt = pin_dis_r;
    if (commit && hit_addr(avs_address, ACC_OFS_CTRL)) begin
      ctrl_nxt = avs_writedata[7:0];
    end
    if (commit && hit_addr(avs_address, ACC_OFS_CONV_B)) begin
      conv_b_nxt = 8'h00;
      conv_b_nxt[ACC_BIT_MUX_EN] = avs_writedata[ACC_BIT_MUX_EN];
    end
    if (commit && hit_addr(avs_address, ACC_OFS_PIN_DIS)) begin
      pin_dis_nxt = {6'h00, avs_writedata[1:0]};
    end
    ctrl_nxt[ACC_BIT_RESULT] = result;
    ctrl_nxt[ACC_BIT_FLAG] = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r <= ACC_RST_CTRL;
      conv_b_r <= ACC_RST_CONV_B;
      pin_dis_r <= ACC_RST_PIN_DIS;
    end else begin
      ctrl_r <= ctrl_nxt;
      conv_b_r <= conv_b_nxt;
      pin_dis_r <= pin_dis_nxt;
    end
  end

  // analogue steering, capture route, request and pin masking
  always_comb begin
    neg_mux_nxt = conv_b_r[ACC_BIT_MUX_EN] && !converter_enable;
    neg_chan_nxt = channel_select_field;
    capture_nxt = ctrl_r[ACC_BIT_CAPTURE] && result;
    irq_nxt = flag && ctrl_r[ACC_BIT_IRQ_EN] && global_irq_enable;
    pin_read_nxt = pin_level & ~pin_dis_r[1:0];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      neg_mux_r <= 1'b0;
      neg_chan_r <= 3'h0;
      capture_r <= 1'b0;
      irq_r <= 1'b0;
      pin_read_r <= 2'h0;
    end else begin
      neg_mux_r <= neg_mux_nxt;
      neg_chan_r <= neg_chan_nxt;
      capture_r <= capture_nxt;
      irq_r <= irq_nxt;
      pin_read_r <= pin_read_nxt;
    end
  end

  always_comb begin
    avs_readdata = rdata_r;
    avs_waitrequest = wait_r;
    // the flag bit is read from the flag flop
    if (bus_state_r == ACC_BUS_ANS && hit_addr(avs_address, ACC_OFS_CTRL)) begin
      avs_readdata[ACC_BIT_FLAG] = flag_rd_r;
    end
  end

  // the flag bit of the read word is taken from the live flag when captured
  always_comb begin
    flag_rd_nxt = flag;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_rd_r <= 1'b0;
    end else begin
      flag_rd_r <= flag_rd_nxt;
    end
  end

  assign comparator_power_off = ctrl_r[ACC_BIT_POWER_OFF];
  assign bandgap_select = ctrl_r[ACC_BIT_BANDGAP];
  assign neg_use_mux = neg_mux_r;
  assign neg_channel = neg_chan_r;
  assign capture_trigger = capture_r;
  assign comparator_irq = irq_r;
  assign negative_pin_buffer_off = pin_dis_r[ACC_BIT_NEG_BUF_OFF];
  assign positive_pin_buffer_off = pin_dis_r[ACC_BIT_POS_BUF_OFF];
  assign pin_read = pin_read_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_bus_answer: assert property (
    bus_state_r == ACC_BUS_IDLE && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not exactly one cycle after request");
  a_neg_mux_pick: assert property (
    conv_b_r[ACC_BIT_MUX_EN] && !converter_enable |=> neg_use_mux
      && neg_channel == $past(channel_select_field))
    else $error("converter pin not selected as negative input");
  a_neg_pin_default: assert property (
    !conv_b_r[ACC_BIT_MUX_EN] || converter_enable |=> !neg_use_mux)
    else $error("dedicated negative pin not selected");
  a_bandgap_write: assert property (
    commit && hit_addr(avs_address, ACC_OFS_CTRL) |=>
      bandgap_select == $past(avs_writedata[ACC_BIT_BANDGAP]))
    else $error("bandgap select does not follow write");
  a_power_off_write: assert property (
    commit && hit_addr(avs_address, ACC_OFS_CTRL) |=>
      comparator_power_off == $past(avs_writedata[ACC_BIT_POWER_OFF]))
    else $error("power-off bit does not follow write");
  a_irq_gate: assert property (
    comparator_irq |-> $past(flag) && $past(ctrl_r[ACC_BIT_IRQ_EN]) && $past(global_irq_enable))
    else $error("interrupt request without flag and both enables");
  a_capture_route: assert property (
    !ctrl_r[ACC_BIT_CAPTURE] |=> !capture_trigger)
    else $error("capture driven while route disabled");
  a_capture_follow: assert property (
    ctrl_r[ACC_BIT_CAPTURE] ##1 ctrl_r[ACC_BIT_CAPTURE] |=> capture_trigger == $past(result))
    else $error("capture output does not follow result");
  a_pin_masked: assert property (
    pin_dis_r[1:0] == 2'h3 |=> pin_read == 2'h0)
    else $error("disabled pin reads non-zero");
  a_flag_w1c: assert property (
    sw_clear && flag && !$changed(result) |=> !flag)
    else $error("write of one left flag set");

  c_irq_raised: cover property (comparator_irq);
  c_capture_pulse: cover property (!capture_trigger ##1 capture_trigger);
  c_mux_used: cover property (neg_use_mux && neg_channel == 3'h7);
  c_flag_cleared: cover property (flag && sw_clear ##1 !flag);

endmodule

// file: sim/acc_far_model.sv
// far-side model: analogue inputs, comparator core and timer capture edge counter
`timescale 1ns/100ps
module acc_far_model #(
  parameter int BG_MV = 1100
) (
  input wire logic clk_sys,
  input wire logic bandgap_select,
  input wire logic neg_use_mux,
  input wire logic [2:0] neg_channel,
  input wire logic comparator_power_off,
  input wire logic capture_trigger,
  input var int pos_mv,
  input var int neg_mv,
  output logic comparator_raw,
  output int cap_rises
);
  int pos_v;
  int neg_v;
  int rises = 0;
  logic cap_d = 1'b0;
  // converter pin k sits at 100*k mV
  always_comb begin
    pos_v = bandgap_select ? BG_MV : pos_mv;
    // converter power reduction is taken as held off while the mux is used
    neg_v = neg_use_mux ? 100 * int'(neg_channel) : neg_mv;
    comparator_raw = !comparator_power_off && (pos_v > neg_v);
  end
  assign cap_rises = rises;
  // timer capture interrupt enable is taken as set, so every rise is counted
  always @(posedge clk_sys) begin
    cap_d <= capture_trigger;
    if (capture_trigger && !cap_d) begin
      rises <= rises + 1;
    end
  end
endmodule

// file: sim/acc_top_tb.sv
// self-checking bench of the comparator control block
`timescale 1ns/100ps
module acc_top_tb;
  import acc_pkg::*;
  logic clk_sys, srst, avs_read, avs_write, avs_waitrequest, comparator_raw;
  logic converter_enable, global_irq_enable, irq_vector_ack;
  logic comparator_power_off, bandgap_select, neg_use_mux, capture_trigger, comparator_irq;
  logic positive_pin_buffer_off, negative_pin_buffer_off;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [2:0] channel_select_field, neg_channel;
  logic [1:0] pin_level, pin_read;
  int pos_mv, neg_mv, cap_rises;
  int err_count = 0;
  int n_checks = 0;

  acc_top dut (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .comparator_raw(comparator_raw),
    .converter_enable(converter_enable), .channel_select_field(channel_select_field),
    .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
    .pin_level(pin_level), .comparator_power_off(comparator_power_off),
    .bandgap_select(bandgap_select), .neg_use_mux(neg_use_mux), .neg_channel(neg_channel),
    .capture_trigger(capture_trigger), .comparator_irq(comparator_irq),
    .positive_pin_buffer_off(positive_pin_buffer_off),
    .negative_pin_buffer_off(negative_pin_buffer_off), .pin_read(pin_read));

  acc_far_model far (.clk_sys(clk_sys), .bandgap_select(bandgap_select),
    .neg_use_mux(neg_use_mux), .neg_channel(neg_channel),
    .comparator_power_off(comparator_power_off), .capture_trigger(capture_trigger),
    .pos_mv(pos_mv), .neg_mv(neg_mv), .comparator_raw(comparator_raw), .cap_rises(cap_rises));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one access; request held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_read <= !wr_en;
    avs_write <= wr_en;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 50) err_count++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'h1, q);
    check(q & m, exp);
  endtask

  task automatic ack_pulse;
    irq_vector_ack <= 1'b1;
    cyc(1);
    irq_vector_ack <= 1'b0;
    cyc(3);
  endtask

  initial begin
    logic [31:0] q;
    srst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    converter_enable = 1'b0;
    channel_select_field = 3'h0;
    global_irq_enable = 1'b1;
    irq_vector_ack = 1'b0;
    pin_level = 2'h0;
    pos_mv = 350;
    neg_mv = 500;
    cyc(6);
    srst <= 1'b0;
    cyc(1);
    // reset values; flag bit is masked out of the control check
    rdc(ACC_OFS_CTRL, 32'hffffffef, 32'h0);
    rdc(ACC_OFS_CONV_B, '1, 32'h0);
    rdc(ACC_OFS_PIN_DIS, '1, 32'h0);
    rdc(8'h5c, '1, 32'h0);
    wr(ACC_OFS_CONV_B, 8'h40);
    for (int k = 0; k < 8; k++) begin
      channel_select_field <= k[2:0];
      cyc(4);
      check({neg_use_mux, 28'h0, neg_channel}, {1'b1, 28'h0, k[2:0]});
      rdc(ACC_OFS_CTRL, 32'h20, (k < 4) ? 32'h20 : 32'h0);
    end
    channel_select_field <= 3'h0;
    converter_enable <= 1'b1;
    cyc(4);
    check(neg_use_mux, 1'b0);
    rdc(ACC_OFS_CTRL, 32'h20, 32'h0);
    converter_enable <= 1'b0;
    wr(ACC_OFS_CONV_B, 8'h00);
    cyc(3);
    check(neg_use_mux, 1'b0);
    wr(ACC_OFS_CTRL, 8'h40);
    cyc(3);
    check(bandgap_select, 1'b1);
    rdc(ACC_OFS_CTRL, 32'h60, 32'h60);
    // keep the bandgap on so the result stays high and the route sees one clean rise
    wr(ACC_OFS_CTRL, 8'h44);
    pos_mv <= 600;
    cyc(5);
    check(capture_trigger, 1'b1);
    check(cap_rises, 32'h1);
    wr(ACC_OFS_CTRL, 8'h00);
    cyc(2);
    check(capture_trigger, 1'b0);
    pos_mv <= 400;
    cyc(5);
    for (int m = 0; m < 4; m++) begin
      wr(ACC_OFS_CTRL, m[7:0]);
      wr(ACC_OFS_CTRL, 8'h10 | m[7:0]);
      wr(ACC_OFS_CTRL, 8'h08 | m[7:0]);
      pos_mv <= 600;
      cyc(6);
      check(comparator_irq, m == 0 || m == 3);
      if (m == 0 || m == 3) begin
        wr(ACC_OFS_CTRL, 8'h08 | m[7:0]);
        cyc(2);
        check(comparator_irq, 1'b1);
        ack_pulse;
        check(comparator_irq, 1'b0);
      end
      pos_mv <= 400;
      cyc(6);
      check(comparator_irq, m == 0 || m == 2);
      global_irq_enable <= 1'b0;
      cyc(3);
      check(comparator_irq, 1'b0);
      global_irq_enable <= 1'b1;
      cyc(3);
      check(comparator_irq, m == 0 || m == 2);
      wr(ACC_OFS_CTRL, 8'h18 | m[7:0]);
      cyc(2);
      check(comparator_irq, 1'b0);
      wr(ACC_OFS_CTRL, m[7:0]);
    end
    wr(ACC_OFS_CTRL, 8'h80);
    pos_mv <= 600;
    cyc(4);
    check(comparator_power_off, 1'b1);
    rdc(ACC_OFS_CTRL, 32'ha0, 32'h80);
    pin_level <= 2'b11;
    wr(ACC_OFS_PIN_DIS, 8'h01);
    cyc(2);
    check({negative_pin_buffer_off, positive_pin_buffer_off, pin_read}, 4'b0110);
    wr(ACC_OFS_PIN_DIS, 8'h02);
    cyc(2);
    check({negative_pin_buffer_off, positive_pin_buffer_off, pin_read}, 4'b1001);
    bus(1'b1, ACC_OFS_PIN_DIS, 8'h03, 4'h0, q);
    rdc(ACC_OFS_PIN_DIS, '1, 32'h2);
    close_out;
  end

  // cut a hang short
  initial begin
    #100000;
    err_count++;
    close_out;
  end
endmodule
